// ===== core/sac_top.sv
// Purpose: Converter control with APB registers and start selection
// Assumes: Timer overflow and start inputs synchronous to core_clk
// Notes: APB answers after one wait state; unmapped gives pslverr
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module sac_top
    import sac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tmr0_ovf,
    input wire logic tmr1_ovf,
    input wire logic [3:0] tmr_lo_ovf,
    input wire logic [3:0] tmr_hi_ovf,
    input wire logic [3:0] tmr_split,
    input wire logic ext_start_in,
    input wire logic low_power_state,
    input wire logic cmp_in,
    output logic [9:0] dac_code,
    output logic analog_pwr,
    output logic track_en,
    output logic irq
);
    sac_sar_if sar ();

    logic conv_enable_q;
    logic track_mode_select_q;
    logic sby_track_off_q;
    logic [2:0] start_source_select_q;
    logic [DIV_W-1:0] conv_clock_divider_q;
    logic stat_q;
    logic ien_q;
    logic irq_q;
    logic busy_prev_q;
    logic ext_prev_q;
    logic analog_pwr_q;
    logic track_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic wr;
    logic sw_go;
    logic ext_rise;
    logic trig;
    logic set_done;
    logic clr_done;
    logic [7:0] rd_val;
    logic rd_ok;

    // Assertions below share this clock and reset
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // Helpers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    function automatic logic tmr_ovf(input logic lo, input logic hi,
                                     input logic split);
        return split ? lo : hi;
    endfunction

    // ==========================================================
    // APB handshake: one wait state, write lands on the pready edge
    assign wr = psel && penable && pwrite && pready_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !rd_ok;
            if (psel && penable && !pready_q) begin
                prdata_q <= (rd_ok && !pwrite) ? {24'h00_0000, rd_val}
                                              : 32'h0000_0000;
            end
        end
    end

    // Read mux and address map
    always_comb begin
        rd_val = 8'h00;
        rd_ok = (paddr[1:0] == 2'h0);
        if (hit(paddr, OFS_CTRL)) begin
            rd_val[CTRL_EN_BIT] = conv_enable_q;
            rd_val[CTRL_TM_BIT] = track_mode_select_q;
            rd_val[CTRL_DONE_BIT] = stat_q;
            rd_val[CTRL_BUSY_BIT] = sar.busy;
            rd_val[CTRL_SBY_BIT] = sby_track_off_q;
            rd_val[CTRL_SRC_LSB +: SRC_W] = start_source_select_q;
        end else if (hit(paddr, OFS_CFG)) begin
            rd_val[CFG_DIV_LSB +: DIV_W] = conv_clock_divider_q;
        end else if (hit(paddr, OFS_RES_HI)) begin
            rd_val[1:0] = sar.result[9:8];
        end else if (hit(paddr, OFS_RES_LO)) begin
            rd_val = sar.result[7:0];
        end else if (hit(paddr, OFS_IRQ_STAT)) begin
            rd_val[0] = stat_q;
        end else if (hit(paddr, OFS_IRQ_EN)) begin
            rd_val[0] = ien_q;
        end else if (!hit(paddr, OFS_IRQ_CLR)) begin
            rd_ok = 1'b0;
        end
    end

    // ==========================================================
    // Control and configuration registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            conv_enable_q <= CTRL_RST[CTRL_EN_BIT];
            track_mode_select_q <= CTRL_RST[CTRL_TM_BIT];
            sby_track_off_q <= CTRL_RST[CTRL_SBY_BIT];
            start_source_select_q <= CTRL_RST[CTRL_SRC_LSB +: SRC_W];
            conv_clock_divider_q <= DIV_RST;
            ien_q <= IRQ_EN_RST;
        end else if (wr) begin
            if (hit(paddr, OFS_CTRL)) begin
                conv_enable_q <= pwdata[CTRL_EN_BIT];
                track_mode_select_q <= pwdata[CTRL_TM_BIT];
                sby_track_off_q <= pwdata[CTRL_SBY_BIT];
                start_source_select_q <= pwdata[CTRL_SRC_LSB +: SRC_W];
            end
            if (hit(paddr, OFS_CFG)) begin
                conv_clock_divider_q <= pwdata[CFG_DIV_LSB +: DIV_W];
            end
            if (hit(paddr, OFS_IRQ_EN)) begin
                ien_q <= pwdata[0];
            end
        end
    end

    // ==========================================================
    // Start source selection
    assign sw_go = wr && hit(paddr, OFS_CTRL) && pwdata[CTRL_BUSY_BIT]
                   && start_source_select_q == SRC_SW;
    assign ext_rise = ext_start_in && !ext_prev_q;

    always_comb begin
        trig = 1'b0;
        // Eight sources picked by the select field
        unique case (start_source_select_q)
            SRC_SW: trig = sw_go;
            SRC_T0: trig = tmr0_ovf;
            SRC_T2: trig = tmr_ovf(tmr_lo_ovf[0], tmr_hi_ovf[0], tmr_split[0]);
            SRC_T1: trig = tmr1_ovf;
            SRC_EXT: trig = ext_rise;
            SRC_T3: trig = tmr_ovf(tmr_lo_ovf[1], tmr_hi_ovf[1], tmr_split[1]);
            SRC_T4: trig = tmr_ovf(tmr_lo_ovf[2], tmr_hi_ovf[2], tmr_split[2]);
            SRC_T5: trig = tmr_ovf(tmr_lo_ovf[3], tmr_hi_ovf[3], tmr_split[3]);
        endcase
    end

    // Edge and level history
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ext_prev_q <= 1'b0;
            busy_prev_q <= 1'b0;
        end else begin
            ext_prev_q <= ext_start_in;
            busy_prev_q <= sar.busy;
        end
    end

    // ==========================================================
    // Sequencer hookup
    assign sar.enable = conv_enable_q;
    assign sar.start = trig && conv_enable_q;
    // External start in low-power mode has tracked already
    assign sar.lp_track = track_mode_select_q
                          && start_source_select_q != SRC_EXT;
    assign sar.cmp = cmp_in;

    sac_clkdiv u_div (
        .core_clk(core_clk),
        .rst(rst),
        .run(conv_enable_q),
        .div(conv_clock_divider_q),
        .tick(sar.tick)
    );

    sac_sar_engine u_eng (
        .core_clk(core_clk),
        .rst(rst),
        .sar(sar)
    );

    // ==========================================================
    // Completion flag: set wins over a clear in the same cycle
    assign set_done = busy_prev_q && !sar.busy && conv_enable_q;
    assign clr_done = wr && hit(paddr, OFS_IRQ_CLR) && pwdata[0];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            stat_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            if (set_done) begin
                stat_q <= 1'b1;
            end else if (clr_done) begin
                stat_q <= 1'b0;
            end
            irq_q <= stat_q && ien_q;
        end
    end

    // ==========================================================
    // Analog side controls
    always_ff @(posedge core_clk) begin
        if (rst) begin
            analog_pwr_q <= 1'b0;
            track_q <= 1'b0;
        end else begin
            analog_pwr_q <= conv_enable_q;
            if (!conv_enable_q || sar.busy && !sar.tracking) begin
                track_q <= 1'b0;
            end else if (sby_track_off_q && low_power_state) begin
                track_q <= 1'b0;
            end else if (!track_mode_select_q) begin
                track_q <= 1'b1;
            end else if (start_source_select_q == SRC_EXT) begin
                track_q <= !ext_start_in;
            end else begin
                track_q <= sar.tracking;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dac_code = sar.code; // Live trial register, no lag at compare
    assign analog_pwr = analog_pwr_q;
    assign track_en = track_q;
    assign irq = irq_q;

    // ==========================================================
    // Checks
    sequence sw_write_s;
        sw_go && conv_enable_q && !sar.busy;
    endsequence

    off_idle_a: assert property (
        !conv_enable_q |=> !sar.busy && !analog_pwr_q)
        else $error("converter active while disabled");

    sw_start_a: assert property (
        sw_write_s |=> sar.busy)
        else $error("software start did not raise busy");

    ext_start_a: assert property (
        (start_source_select_q == SRC_EXT && ext_start_in && !ext_prev_q
         && conv_enable_q && !sar.busy) |=> sar.busy)
        else $error("external rising edge missed");

    done_set_a: assert property (
        ($fell(sar.busy) && conv_enable_q) |=> stat_q ##1 (irq_q == ien_q))
        else $error("done flag or interrupt missing after busy fell");

    result_hold_a: assert property (
        (stat_q && !sar.busy && $past(stat_q)) |-> $stable(sar.result))
        else $error("result moved while done flag set");

    track_conv_a: assert property (
        (sar.busy && !sar.tracking) |=> !track_q)
        else $error("tracking during conversion");

    busy_read_a: assert property (
        (psel && penable && !pready_q && !pwrite && hit(paddr, OFS_CTRL))
        |=> prdata_q[CTRL_BUSY_BIT] == $past(sar.busy))
        else $error("busy bit read wrong");

    lp_ext_a: assert property (
        (conv_enable_q && track_mode_select_q && !sar.busy
         && start_source_select_q == SRC_EXT && !ext_start_in
         && !(sby_track_off_q && low_power_state)) |=> track_q)
        else $error("no tracking while start input low");
endmodule

// ===== common/sac_pkg.sv
// Purpose: Shared constants and types of the converter control block
// Assumes: APB byte addresses, 8-bit registers in the low data bits
// Notes: All offsets, the CTRL and CFG field positions and their reset values live here
package sac_pkg;

    // ==========================================================
    // Converter geometry
    localparam int RES_BITS = 10;
    localparam logic [1:0] TRACK_CLKS = 2'h3;
    localparam logic [3:0] MSB_IDX = 4'h9;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CFG = 8'h04;
    localparam logic [7:0] OFS_RES_HI = 8'h08;
    localparam logic [7:0] OFS_RES_LO = 8'h0c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN = 8'h18;

    // ==========================================================
    // Control and configuration register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_TM_BIT = 6;
    localparam int CTRL_DONE_BIT = 5;
    localparam int CTRL_BUSY_BIT = 4;
    localparam int CTRL_SBY_BIT = 3;
    localparam int CTRL_SRC_LSB = 0;
    localparam int SRC_W = 3;
    localparam int CFG_DIV_LSB = 3;
    localparam int DIV_W = 5;

    // ==========================================================
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [DIV_W-1:0] DIV_RST = 5'h1f;
    localparam logic IRQ_EN_RST = 1'b0;

    // ==========================================================
    // Start source codes
    localparam logic [2:0] SRC_SW = 3'h0;
    localparam logic [2:0] SRC_T0 = 3'h1;
    localparam logic [2:0] SRC_T2 = 3'h2;
    localparam logic [2:0] SRC_T1 = 3'h3;
    localparam logic [2:0] SRC_EXT = 3'h4;
    localparam logic [2:0] SRC_T3 = 3'h5;
    localparam logic [2:0] SRC_T4 = 3'h6;
    localparam logic [2:0] SRC_T5 = 3'h7;

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_TRACK,
        ST_CONV,
        ST_FINISH
    } sac_state_t;

endpackage

// ===== common/sac_sar_if.sv
// Purpose: Carrier between the control logic and the SAR sequencer
// Assumes: One clock domain
// Notes: Control side drives the requests, engine side the results
`timescale 1ns/1ps
interface sac_sar_if;
    logic enable;
    logic tick;
    logic start;
    logic lp_track;
    logic cmp;
    logic busy;
    logic tracking;
    logic done;
    logic [9:0] code;
    logic [9:0] result;

    modport ctrl (
        output enable, tick, start, lp_track, cmp,
        input busy, tracking, done, code, result
    );
    modport engine (
        input enable, tick, start, lp_track, cmp,
        output busy, tracking, done, code, result
    );
endinterface

// ===== core/sac_clkdiv.sv
// Purpose: Conversion clock enable from the core clock
// Assumes: div selects a period of div+1 core cycles
// Notes: Counter held cleared while the converter is off
`timescale 1ns/1ps
module sac_clkdiv
    import sac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic [sac_pkg::DIV_W-1:0] div,
    output logic tick
);
    logic [DIV_W-1:0] cnt_q;
    logic tick_q;

    // ==========================================================
    // Divider counter and one-cycle enable pulse
    always_ff @(posedge core_clk) begin
        if (rst || !run) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (cnt_q >= div) begin
            cnt_q <= '0;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 5'h01;
            tick_q <= 1'b0;
        end
    end

    assign tick = tick_q;
endmodule

// ===== core/sac_sar_engine.sv
// Purpose: Track, bit-by-bit approximation and finish sequencing
// Assumes: tick is the conversion clock enable
// Notes: Starts are taken only when idle
`timescale 1ns/1ps
module sac_sar_engine
    import sac_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    sac_sar_if.engine sar
);
    sac_state_t state_q;
    logic [1:0] trk_q;
    logic [3:0] bit_q;
    logic [9:0] code_q;
    logic [9:0] result_q;
    logic done_q;

    // Assertions below share this clock and reset
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ==========================================================
    // Sequencer
    always_ff @(posedge core_clk) begin
        if (rst || !sar.enable) begin
            state_q <= ST_IDLE;
            trk_q <= 2'h0;
            bit_q <= 4'h0;
            code_q <= 10'h000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    // Starts outside idle are dropped
                    if (sar.start) begin
                        trk_q <= 2'h0;
                        bit_q <= MSB_IDX;
                        code_q <= 10'h200;
                        // Low-power mode tracks first
                        state_q <= sar.lp_track ? ST_TRACK : ST_CONV;
                    end
                end
                ST_TRACK: begin
                    if (sar.tick) begin
                        if (trk_q == TRACK_CLKS - 2'h1) begin
                            state_q <= ST_CONV;
                        end else begin
                            trk_q <= trk_q + 2'h1;
                        end
                    end
                end
                ST_CONV: begin
                    // One result bit per tick, MSB first
                    if (sar.tick) begin
                        code_q[bit_q] <= sar.cmp;
                        if (bit_q == 4'h0) begin
                            state_q <= ST_FINISH;
                        end else begin
                            code_q[bit_q - 4'h1] <= 1'b1;
                            bit_q <= bit_q - 4'h1;
                        end
                    end
                end
                ST_FINISH: begin
                    // One tick of overhead
                    if (sar.tick) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Result capture and completion pulse
    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_q <= 10'h000;
            done_q <= 1'b0;
        end else begin
            done_q <= sar.enable && state_q == ST_FINISH && sar.tick;
            if (sar.enable && state_q == ST_FINISH && sar.tick) begin
                result_q <= code_q;
            end
        end
    end

    assign sar.busy = (state_q != ST_IDLE);
    assign sar.tracking = (state_q == ST_TRACK);
    assign sar.done = done_q;
    assign sar.code = code_q;
    assign sar.result = result_q;

    // ==========================================================
    // Checks
    sequence trk_last_s;
        state_q == ST_TRACK && sar.tick && trk_q == 2'h2;
    endsequence

    sequence finish_tick_s;
        state_q == ST_FINISH && sar.tick && sar.enable;
    endsequence

    track_len_a: assert property (
        trk_last_s |=> state_q == ST_CONV || state_q == ST_IDLE)
        else $error("tracking did not end after three ticks");

    track_bound_a: assert property (
        state_q == ST_TRACK |-> trk_q < TRACK_CLKS)
        else $error("tracking count out of range");

    start_ignored_a: assert property (
        (state_q == ST_CONV && sar.start && !sar.tick && sar.enable)
        |=> state_q == ST_CONV && $stable(bit_q))
        else $error("start disturbed a running conversion");

    last_bit_a: assert property (
        (state_q == ST_CONV && sar.tick && bit_q == 4'h0 && sar.enable)
        |=> state_q == ST_FINISH ##1 state_q != ST_CONV)
        else $error("conversion did not finish after last bit");

    finish_done_a: assert property (
        finish_tick_s |=> sar.done && state_q == ST_IDLE
                          && sar.result == $past(code_q))
        else $error("finish tick gave no completion or result");
endmodule

// ===== dv/sac_far_model.sv
// Purpose: Comparator of the analog input against the trial code
// Assumes: Input level held steady through a conversion
// Notes: Behavioural, no settling delay
`timescale 1ns/1ps
module sac_far_model (
    input wire logic [9:0] dac_code,
    input wire logic [9:0] level,
    output logic cmp_in
);
    // High while the input is at or above the trial code
    assign cmp_in = (level >= dac_code);
endmodule

// ===== dv/sac_top_tb_top.sv
// Purpose: Self-checking bench of the converter control block
// Assumes: APB slave answers after one wait state
// Notes: Triggers are one-cycle pulses driven at the rising edge
`timescale 1ns/1ps
module sac_top_tb_top;
    import sac_pkg::*;
    typedef struct packed {
        logic [2:0] src; logic tm; logic [3:0] spl; logic [9:0] lvl;
    } sac_row_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, analog_pwr, track_en, cmp_in, err;
    logic tmr0_ovf = 1'b0, tmr1_ovf = 1'b0, ext_start_in = 1'b0;
    logic low_power_state = 1'b0;
    logic [3:0] tmr_lo_ovf = 4'h0, tmr_hi_ovf = 4'h0, tmr_split = 4'h0;
    logic [9:0] dac_code;
    logic [9:0] level = 10'h000;
    logic [7:0] c;
    int n_mismatch = 0, checks = 0, n, lat0, lat1, lat2;
    sac_row_t rows [8] = '{
        '{3'h0, 1'b0, 4'h0, 10'h2a5}, '{3'h1, 1'b1, 4'h0, 10'h3ff},
        '{3'h2, 1'b0, 4'h1, 10'h000}, '{3'h3, 1'b0, 4'h0, 10'h155},
        '{3'h4, 1'b1, 4'h0, 10'h200}, '{3'h5, 1'b1, 4'h0, 10'h1ff},
        '{3'h6, 1'b0, 4'h4, 10'h0f0}, '{3'h7, 1'b0, 4'h0, 10'h30c}};

    // ==========================================================
    // Design and far side
    sac_top u_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf),
        .tmr_lo_ovf(tmr_lo_ovf), .tmr_hi_ovf(tmr_hi_ovf),
        .tmr_split(tmr_split), .ext_start_in(ext_start_in),
        .low_power_state(low_power_state), .cmp_in(cmp_in),
        .dac_code(dac_code), .analog_pwr(analog_pwr),
        .track_en(track_en), .irq(irq));
    sac_far_model u_far (.dac_code(dac_code), .level(level),
        .cmp_in(cmp_in));

    // ==========================================================
    // Clock and watchdog
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish();
    end

    // ==========================================================
    // Bus and check tasks
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, a, {24'h0, d}, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    // One trigger pulse; wrong picks the unused timer byte
    task automatic pulse(input int s, input logic wrong);
        int i;
        i = (s == 2) ? 0 : s - 4;
        case (s)
            1: tmr0_ovf <= 1'b1;
            3: tmr1_ovf <= 1'b1;
            4: ext_start_in <= 1'b1; // Pin kept off crossbar
            default: begin
                if (tmr_split[i] ^ wrong) tmr_lo_ovf[i] <= 1'b1;
                else tmr_hi_ovf[i] <= 1'b1;
            end
        endcase
        @(posedge core_clk);
        tmr0_ovf <= 1'b0;
        tmr1_ovf <= 1'b0;
        tmr_lo_ovf <= 4'h0;
        tmr_hi_ovf <= 4'h0;
        ext_start_in <= 1'b0;
    endtask
    task automatic wirq(input int lim, output int k);
        k = 0;
        while (irq !== 1'b1 && k < lim) begin
            @(posedge core_clk);
            k++;
        end
        chk({31'h0, irq}, 32'h1);
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(posedge core_clk);
        chk({30'h0, analog_pwr, irq}, 32'h0);
        rst <= 1'b0;
        rd(OFS_CTRL, {24'h0, CTRL_RST});
        rd(OFS_CFG, {24'h0, DIV_RST, 3'h0});
        rd(OFS_IRQ_EN, {31'h0, IRQ_EN_RST});
        rd(OFS_IRQ_STAT, 32'h0);
        rd(8'h1c, 32'h0);
        chk({31'h0, err}, 32'h1);
        rd(8'h02, 32'h0);
        chk({31'h0, err}, 32'h1);
        wr(OFS_CFG, 8'h00);
        wr(OFS_IRQ_EN, 8'h01);
        foreach (rows[k]) begin
            level <= rows[k].lvl;
            tmr_split <= rows[k].spl;
            c = {1'b1, rows[k].tm, 3'h0, rows[k].src};
            wr(OFS_CTRL, c);
            // Tracking output settles one cycle after the write
            @(posedge core_clk);
            if (!rows[k].tm || rows[k].src == SRC_EXT)
                chk({31'h0, track_en}, 32'h1);
            if (rows[k].src == SRC_SW) wr(OFS_CTRL, c | 8'h10);
            else begin
                if (rows[k].src inside {SRC_T2, SRC_T3, SRC_T4, SRC_T5}) begin
                    pulse(rows[k].src, 1'b1);
                    repeat (30) @(posedge core_clk);
                    rd(OFS_IRQ_STAT, 32'h0);
                end
                pulse(rows[k].src, 1'b0);
            end
            wirq(100, n);
            rd(OFS_IRQ_STAT, 32'h1);
            rd(OFS_RES_HI, {30'h0, rows[k].lvl[9:8]});
            rd(OFS_RES_LO, {24'h0, rows[k].lvl[7:0]});
            rd(OFS_CTRL, {24'h0, c | 8'h20});
            wr(OFS_IRQ_CLR, 8'h01);
            rd(OFS_IRQ_STAT, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        // Latency: low-power track adds three ticks, divider stretches
        wr(OFS_CTRL, 8'h81);
        pulse(1, 1'b0);
        wirq(100, lat0);
        wr(OFS_IRQ_CLR, 8'h01);
        wr(OFS_CTRL, 8'hc1);
        pulse(1, 1'b0);
        wirq(100, lat1);
        wr(OFS_IRQ_CLR, 8'h01);
        chk(lat1 - lat0, 32'h3);
        wr(OFS_CFG, 8'h18);
        wr(OFS_CTRL, 8'h81);
        pulse(1, 1'b0);
        wirq(200, lat2);
        wr(OFS_IRQ_CLR, 8'h01);
        chk(lat2 - lat0 >= 29 && lat2 - lat0 <= 34, 32'h1);
        // Repeated starts during a slow conversion are ignored
        wr(OFS_CFG, 8'hf8);
        wr(OFS_CTRL, 8'h80);
        wr(OFS_CTRL, 8'h90);
        rd(OFS_CTRL, 32'h90);
        repeat (100) @(posedge core_clk);
        wr(OFS_CTRL, 8'h90);
        wirq(400, n);
        rd(OFS_CTRL, 32'ha0);
        wr(OFS_IRQ_CLR, 8'h01);
        // Masked interrupt still sets status
        wr(OFS_CFG, 8'h00);
        wr(OFS_IRQ_EN, 8'h00);
        wr(OFS_CTRL, 8'h90);
        repeat (60) @(posedge core_clk);
        rd(OFS_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(OFS_IRQ_CLR, 8'h01);
        // Disabled converter ignores triggers and stays unpowered
        wr(OFS_CTRL, 8'h01);
        @(posedge core_clk);
        chk({31'h0, analog_pwr}, 32'h0);
        pulse(1, 1'b0);
        repeat (40) @(posedge core_clk);
        rd(OFS_IRQ_STAT, 32'h0);
        // Standby stops tracking when the stop bit is set
        wr(OFS_CTRL, 8'h88);
        low_power_state <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({31'h0, track_en}, 32'h0);
        low_power_state <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk({31'h0, track_en}, 32'h1);
        tally_and_finish();
    end
endmodule
